// [shared/bfr_pkg.sv]
// ============================================================
// shared constants for the bidirectional queue control slice
// ============================================================
package bfr_pkg;

    localparam int DATA_W = 36;
    localparam int QUEUE_DEPTH = 16;
    localparam int BYTE_LAST = 3;
    localparam int WORD_LAST = 1;

    // ========================================================
    // register map (byte addresses)
    // ========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;

    // control register fields
    localparam int CTRL_REPLAY_BIT = 0;
    localparam int CTRL_NARROW_BIT = 1;
    localparam int CTRL_BYTE_BIT = 2;
    localparam int CTRL_BIG_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status register fields
    localparam int STAT_FWD_EMPTY_BIT = 0;
    localparam int STAT_FWD_FULL_BIT = 1;
    localparam int STAT_REV_EMPTY_BIT = 2;
    localparam int STAT_REV_FULL_BIT = 3;
    localparam int STAT_MAIL_N_BIT = 4;
    localparam int STAT_FWD_LVL_POS = 8;
    localparam int STAT_REV_LVL_POS = 16;
    localparam int STAT_LVL_W = 8;

    // ========================================================
    // port b bus width
    // ========================================================
    typedef enum logic [1:0] {
        BFR_LONG,
        BFR_WORD,
        BFR_BYTE
    } bfr_width_e;

    localparam logic [35:0] MASK_LONG = 36'hfffffffff;
    localparam logic [35:0] MASK_WORD = 36'h00003ffff;
    localparam logic [35:0] MASK_BYTE = 36'h0000001ff;
    localparam logic [5:0] CHUNK_WORD = 6'h12;
    localparam logic [5:0] CHUNK_BYTE = 6'h09;

endpackage

// [shared/bfr_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// valid/ready word stream between internal stages
// ============================================================
interface bfr_stream_if #(parameter int W = 36);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [hdl/bfr_skid.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// two-entry buffer with valid/ready on both sides
// ============================================================
module bfr_skid #(
    parameter int W = 36
) (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic flush, // drop held words
    bfr_stream_if.snk in_s, // filling side
    bfr_stream_if.src out_s // draining side
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic take, give;

    assign in_s.ready = (cnt_q != 2'h2);
    assign out_s.valid = (cnt_q != 2'h0);
    assign out_s.data = mem_q[rp_q];
    assign take = in_s.valid && in_s.ready;
    assign give = out_s.valid && out_s.ready;

    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (flush) begin
            wp_d = 1'b0;
            rp_d = 1'b0;
            cnt_d = 2'h0;
        end else begin
            if (take) begin
                mem_d[wp_q] = in_s.data;
                wp_d = ~wp_q;
            end
            if (give) begin
                rp_d = ~rp_q;
            end
            cnt_d = 2'(cnt_q + {1'b0, take} - {1'b0, give});
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// [hdl/bfr_queue.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// one queue: flop storage, partial reset and replay
// ============================================================
module bfr_queue #(
    parameter int W = 36,
    parameter int DEPTH = 16,
    parameter int LW = $clog2(DEPTH) + 1
) (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic prst, // partial reset, both pointers
    input wire logic rtx, // replay, read pointer only
    bfr_stream_if.snk in_s, // write side
    bfr_stream_if.src out_s, // read side, head word shown
    output logic [LW-1:0] level // words held
);
    localparam int AW = LW - 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [LW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic take, give;

    assign level = LW'(wr_q - rd_q);
    assign in_s.ready = (level != LW'(DEPTH)) && !prst;
    assign out_s.valid = (wr_q != rd_q) && !prst && !rtx;
    assign out_s.data = mem_q[rd_q[AW-1:0]];
    assign take = in_s.valid && in_s.ready;
    assign give = out_s.valid && out_s.ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (take) begin
            mem_d[wr_q[AW-1:0]] = in_s.data;
            wr_d = LW'(wr_q + 1'b1);
        end
        if (give) begin
            rd_d = LW'(rd_q + 1'b1);
        end
        if (prst) begin
            wr_d = '0;
            rd_d = '0;
        end else if (rtx) begin
            rd_d = '0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
endmodule
`default_nettype wire

// [hdl/bfr_ctrl.sv]
// Operation
// - forward pin low, replay off: both forward pointers to zero.
// - forward partial reset clears the port B output register.
// - partial reset keeps width, endian and other configuration.
// - forward pin low, replay on: only forward read pointer zeroed.
// - reverse pin low, replay off: both reverse pointers to zero.
// - reverse pin low, replay on: only reverse read pointer zeroed.
// - narrow bus, width select high: port B moves 9-bit bytes.
// - narrow bus, width select low: port B moves 18-bit words.
// - port A direction high writes, low reads.
// - port A outputs undriven while port A writes.
// - port B direction low writes, high reads.
// - port B outputs undriven while port B writes.
// - narrow bus off: port B is a full long-word port.
// - forward reset sets the forward mail flag high.
`timescale 1ns/1ps
`default_nettype none
module bfr_ctrl #(
    parameter int DEPTH = bfr_pkg::QUEUE_DEPTH
) (
    input wire logic clk, // 250 MHz core clock
    input wire logic resetn, // async reset, active low
    // apb slave
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    // queue reset / replay pins
    input wire logic fwd_partial_reset_n, // forward reset/replay
    input wire logic rev_partial_reset_n, // reverse reset/replay
    // port a
    input wire logic porta_xfer_en, // port a enable
    input wire logic porta_select_n, // port a chip select
    input wire logic porta_dir_sel, // 1 write, 0 read
    input wire logic porta_mail_sel, // write goes to mailbox
    input wire logic [bfr_pkg::DATA_W-1:0] porta_din, // port a in
    output logic [bfr_pkg::DATA_W-1:0] porta_dout, // port a out
    output logic porta_dout_oe, // port a drive enable
    output logic porta_in_ready, // port a write accepted
    // port b
    input wire logic portb_xfer_en, // port b enable
    input wire logic portb_select_n, // port b chip select
    input wire logic portb_dir_sel, // 0 write, 1 read
    input wire logic portb_mail_sel, // read comes from mailbox
    input wire logic [bfr_pkg::DATA_W-1:0] portb_din, // port b in
    output logic [bfr_pkg::DATA_W-1:0] portb_dout, // port b out
    output logic portb_dout_oe, // port b drive enable
    output logic portb_in_ready, // port b write accepted
    output logic fwd_mail_full_n // 0 while mail waits
);
    import bfr_pkg::*;

    localparam int LW = $clog2(DEPTH) + 1;

    // ========================================================
    // internal streams and queues
    // ========================================================
    bfr_stream_if #(.W(DATA_W)) pa_s ();
    bfr_stream_if #(.W(DATA_W)) fq_in ();
    bfr_stream_if #(.W(DATA_W)) fq_out ();
    bfr_stream_if #(.W(DATA_W)) rq_in ();
    bfr_stream_if #(.W(DATA_W)) rq_out ();

    logic [LW-1:0] fwd_level, rev_level;
    logic fwd_prst, fwd_rtx, rev_prst, rev_rtx;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic replay_mode_sel, narrow_bus_sel;

    assign replay_mode_sel = ctrl_q[CTRL_REPLAY_BIT];
    assign narrow_bus_sel = ctrl_q[CTRL_NARROW_BIT];

    // reset pins act level-wise every edge they are held low
    assign fwd_prst = !fwd_partial_reset_n && !replay_mode_sel;
    assign fwd_rtx = !fwd_partial_reset_n && replay_mode_sel;
    assign rev_prst = !rev_partial_reset_n && !replay_mode_sel;
    assign rev_rtx = !rev_partial_reset_n && replay_mode_sel;

    bfr_skid #(.W(DATA_W)) u_pa_skid (
        .clk(clk),
        .resetn(resetn),
        .flush(fwd_prst),
        .in_s(pa_s),
        .out_s(fq_in)
    );

    bfr_queue #(.W(DATA_W), .DEPTH(DEPTH), .LW(LW)) u_fwd (
        .clk(clk),
        .resetn(resetn),
        .prst(fwd_prst),
        .rtx(fwd_rtx),
        .in_s(fq_in),
        .out_s(fq_out),
        .level(fwd_level)
    );

    bfr_queue #(.W(DATA_W), .DEPTH(DEPTH), .LW(LW)) u_rev (
        .clk(clk),
        .resetn(resetn),
        .prst(rev_prst),
        .rtx(rev_rtx),
        .in_s(rq_in),
        .out_s(rq_out),
        .level(rev_level)
    );

    // ========================================================
    // port b width
    // ========================================================
    bfr_width_e width_m;
    logic [1:0] last_idx;
    logic [35:0] chunk_m;
    logic [5:0] chunk_w;

    // width is a static strap: no realignment on change
    always_comb begin
        width_m = BFR_LONG;
        if (!narrow_bus_sel) begin
            width_m = BFR_LONG;
        end else if (ctrl_q[CTRL_BYTE_BIT]) begin
            width_m = BFR_BYTE;
        end else begin
            width_m = BFR_WORD;
        end
    end

    always_comb begin
        last_idx = 2'h0;
        chunk_m = MASK_LONG;
        chunk_w = 6'h00;
        case (width_m)
            BFR_BYTE: begin
                last_idx = 2'(BYTE_LAST);
                chunk_m = MASK_BYTE;
                chunk_w = CHUNK_BYTE;
            end
            BFR_WORD: begin
                last_idx = 2'(WORD_LAST);
                chunk_m = MASK_WORD;
                chunk_w = CHUNK_WORD;
            end
            default: begin
                last_idx = 2'h0;
                chunk_m = MASK_LONG;
                chunk_w = 6'h00;
            end
        endcase
    end

    // big endian moves the most significant chunk first
    function automatic logic [5:0] chunk_shift(input logic [1:0] idx,
            input logic [1:0] last, input logic big, input logic [5:0] cw);
        logic [1:0] pos;
        pos = big ? 2'(last - idx) : idx;
        return 6'(cw * {4'h0, pos});
    endfunction

    // ========================================================
    // port decode
    // ========================================================
    logic pa_act, pa_rd, pa_wr, pb_act, pb_rd, pb_wr;

    assign pa_act = porta_xfer_en && !porta_select_n;
    assign pa_wr = pa_act && porta_dir_sel;
    assign pa_rd = pa_act && !porta_dir_sel;
    assign pb_act = portb_xfer_en && !portb_select_n;
    assign pb_wr = pb_act && !portb_dir_sel;
    assign pb_rd = pb_act && portb_dir_sel;

    // port a words pass the buffer first
    assign pa_s.valid = pa_wr && !porta_mail_sel;
    assign pa_s.data = porta_din;
    assign porta_in_ready = pa_s.ready;

    assign porta_dout_oe = pa_act && !porta_dir_sel;
    assign portb_dout_oe = pb_act && portb_dir_sel;

    // ========================================================
    // data path state
    // ========================================================
    logic [DATA_W-1:0] pa_out_q, pa_out_d, pb_out_q, pb_out_d;
    logic [DATA_W-1:0] mail_q, mail_d, asm_q, asm_d;
    logic mail_n_q, mail_n_d;
    logic [1:0] rd_idx_q, rd_idx_d, wr_idx_q, wr_idx_d;
    logic [5:0] rd_sh, wr_sh;
    logic [35:0] wr_word;
    logic big;

    assign big = ctrl_q[CTRL_BIG_BIT];
    assign rd_sh = chunk_shift(rd_idx_q, last_idx, big, chunk_w);
    assign wr_sh = chunk_shift(wr_idx_q, last_idx, big, chunk_w);
    assign wr_word = (asm_q & ~(chunk_m << wr_sh))
        | ((portb_din & chunk_m) << wr_sh);

    assign rq_in.data = wr_word;
    assign rq_in.valid = pb_wr && !rev_prst && (wr_idx_q == last_idx);
    assign portb_in_ready = (wr_idx_q != last_idx) || rq_in.ready;
    assign rq_out.ready = pa_rd;
    assign fq_out.ready = pb_rd && !portb_mail_sel
        && (rd_idx_q == last_idx);

    always_comb begin
        pa_out_d = pa_out_q;
        pb_out_d = pb_out_q;
        mail_d = mail_q;
        mail_n_d = mail_n_q;
        asm_d = asm_q;
        rd_idx_d = rd_idx_q;
        wr_idx_d = wr_idx_q;
        // mailbox
        if (pa_wr && porta_mail_sel && mail_n_q) begin
            mail_d = porta_din;
            mail_n_d = 1'b0;
        end
        // port b read, chunked from the forward head word
        if (pb_rd && portb_mail_sel) begin
            pb_out_d = mail_q & chunk_m;
            mail_n_d = 1'b1;
        end else if (pb_rd && fq_out.valid) begin
            pb_out_d = (fq_out.data >> rd_sh) & chunk_m;
            rd_idx_d = (rd_idx_q == last_idx) ? 2'h0
                : 2'(rd_idx_q + 1'b1);
        end
        // port b write, assembled into a reverse word
        if (pb_wr && portb_in_ready) begin
            asm_d = (wr_idx_q == last_idx) ? '0 : wr_word;
            wr_idx_d = (wr_idx_q == last_idx) ? 2'h0
                : 2'(wr_idx_q + 1'b1);
        end
        // port a read of the reverse queue
        if (pa_rd && rq_out.valid) begin
            pa_out_d = rq_out.data;
        end
        if (fwd_prst) begin
            pb_out_d = '0;
            mail_n_d = 1'b1;
            rd_idx_d = 2'h0;
        end else if (fwd_rtx) begin
            rd_idx_d = 2'h0;
        end
        if (rev_prst) begin
            pa_out_d = '0;
            asm_d = '0;
            wr_idx_d = 2'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pa_out_q <= '0;
            pb_out_q <= '0;
            mail_q <= '0;
            mail_n_q <= 1'b1;
            asm_q <= '0;
            rd_idx_q <= 2'h0;
            wr_idx_q <= 2'h0;
        end else begin
            pa_out_q <= pa_out_d;
            pb_out_q <= pb_out_d;
            mail_q <= mail_d;
            mail_n_q <= mail_n_d;
            asm_q <= asm_d;
            rd_idx_q <= rd_idx_d;
            wr_idx_q <= wr_idx_d;
        end
    end

    assign porta_dout = pa_out_q;
    assign portb_dout = pb_out_q;
    assign fwd_mail_full_n = mail_n_q;

    // ========================================================
    // apb slave: data loaded in setup, answered in access
    // ========================================================
    logic [31:0] prdata_q, prdata_d, stat;
    logic err_q, err_d, setup, access;

    assign setup = psel && !penable;
    assign access = psel && penable;

    always_comb begin
        stat = '0;
        stat[STAT_FWD_EMPTY_BIT] = !fq_out.valid;
        stat[STAT_FWD_FULL_BIT] = !fq_in.ready;
        stat[STAT_REV_EMPTY_BIT] = !rq_out.valid;
        stat[STAT_REV_FULL_BIT] = !rq_in.ready;
        stat[STAT_MAIL_N_BIT] = mail_n_q;
        stat[STAT_FWD_LVL_POS +: STAT_LVL_W] = STAT_LVL_W'(fwd_level);
        stat[STAT_REV_LVL_POS +: STAT_LVL_W] = STAT_LVL_W'(rev_level);
    end

    // partial resets never touch ctrl_q
    always_comb begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        err_d = err_q;
        if (setup) begin
            if (paddr == ADDR_CTRL) begin
                prdata_d = {28'h0000000, ctrl_q};
                err_d = 1'b0;
            end else if (paddr == ADDR_STAT) begin
                prdata_d = stat;
                err_d = 1'b0;
            end else begin
                prdata_d = '0;
                err_d = 1'b1;
            end
        end
        if (access && pwrite && paddr == ADDR_CTRL) begin
            ctrl_d = pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= CTRL_RESET;
            prdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access && err_q;
endmodule
`default_nettype wire

// [bench/bfr_portb_agent.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// far-side port b master driven by bench commands
// ====================================================
module bfr_portb_agent (
    input wire logic clk, // core clock
    input wire logic resetn, // async reset
    input wire logic [1:0] cmd, // 0 idle, 1 read, 2 write
    input wire logic [bfr_pkg::DATA_W-1:0] wdat, // word to write
    output logic xfer_en, // port enable
    output logic select_n, // chip select
    output logic dir_sel, // 1 read, 0 write
    output logic [bfr_pkg::DATA_W-1:0] din // write data
);
    import bfr_pkg::*;
    logic [DATA_W-1:0] last_q;
    logic [DATA_W-1:0] last_d;
    always_comb begin
        last_d = (cmd == 2'd2) ? wdat : last_q;
        xfer_en = (cmd != 2'd0);
        select_n = (cmd == 2'd0);
        dir_sel = (cmd == 2'd1);
        // released bus shows the inverse of the last word
        din = (cmd == 2'd2) ? wdat : ~last_q;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            last_q <= '0;
        else
            last_q <= last_d;
    end
endmodule
`default_nettype wire

// [bench/bfr_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// checks at the control slice ports
// ====================================================
module bfr_ctrl_properties
    import bfr_pkg::*;
(
    input wire logic clk, // clock
    input wire logic resetn, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [7:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic fwd_partial_reset_n, // pin
    input wire logic rev_partial_reset_n, // pin
    input wire logic porta_xfer_en, // a
    input wire logic porta_select_n, // a
    input wire logic porta_dir_sel, // a
    input wire logic [DATA_W-1:0] porta_dout, // a
    input wire logic porta_dout_oe, // a
    input wire logic portb_xfer_en, // b
    input wire logic portb_select_n, // b
    input wire logic portb_dir_sel, // b
    input wire logic portb_mail_sel, // b
    input wire logic [DATA_W-1:0] portb_dout, // b
    input wire logic portb_dout_oe, // b
    input wire logic fwd_mail_full_n // mail
);
    logic [3:0] cfg_q;
    logic [3:0] cfg_d;
    logic rd_b;
    assign rd_b = portb_xfer_en && !portb_select_n && portb_dir_sel
        && !portb_mail_sel;
    always_comb begin
        cfg_d = cfg_q;
        if (psel && penable && pwrite && paddr == ADDR_CTRL)
            cfg_d = pwdata[CTRL_W-1:0];
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            cfg_q <= CTRL_RESET;
        else
            cfg_q <= cfg_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_clr_fwd;
        !fwd_partial_reset_n && !cfg_q[CTRL_REPLAY_BIT];
    endsequence
    sequence s_nar_rd;
        rd_b && cfg_q[CTRL_NARROW_BIT];
    endsequence
    property p_fwd_prst;
        s_clr_fwd |=> portb_dout == '0 && fwd_mail_full_n;
    endproperty
    a_fwd_prst: assert property (p_fwd_prst) else $error("fwd clear");
    property p_rev_prst;
        !rev_partial_reset_n && !cfg_q[CTRL_REPLAY_BIT] |=> porta_dout == '0;
    endproperty
    a_rev_prst: assert property (p_rev_prst) else $error("rev clear");
    property p_a_oe;
        porta_dout_oe == (porta_xfer_en && !porta_select_n && !porta_dir_sel);
    endproperty
    a_a_oe: assert property (p_a_oe) else $error("port a drive");
    property p_b_oe;
        portb_dout_oe == (portb_xfer_en && !portb_select_n && portb_dir_sel);
    endproperty
    a_b_oe: assert property (p_b_oe) else $error("port b drive");
    property p_apb_resp;
        psel && penable |->
            pready && pslverr == (paddr != ADDR_CTRL && paddr != ADDR_STAT);
    endproperty
    a_apb_resp: assert property (p_apb_resp) else $error("apb reply");
    property p_ctrl_rd;
        psel && penable && !pwrite && paddr == ADDR_CTRL
            |-> prdata == {28'h0, cfg_q};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl kept");
    property p_byte;
        s_nar_rd ##0 cfg_q[CTRL_BYTE_BIT] |=> (portb_dout & ~MASK_BYTE) == '0;
    endproperty
    a_byte: assert property (p_byte) else $error("byte width");
    property p_word;
        s_nar_rd ##0 !cfg_q[CTRL_BYTE_BIT] |=> (portb_dout & ~MASK_WORD) == '0;
    endproperty
    a_word: assert property (p_word) else $error("word width");
endmodule
bind bfr_ctrl bfr_ctrl_properties u_props (.*);
`default_nettype wire

// [bench/bfr_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// self-checking bench of the queue control slice
// ====================================================
module bfr_ctrl_tb_top;
    import bfr_pkg::*;
    localparam int DEPTH = 4;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, er, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic fwd_n, rev_n, a_en, a_seln, a_dir, a_oe, a_rdy;
    logic b_en, b_seln, b_dir, b_oe, b_rdy, mail_n, a_mb;
    logic [1:0] b_cmd;
    logic [DATA_W-1:0] a_din, a_dout, b_din, b_dout, b_dat, q, w;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n;
    bfr_ctrl #(.DEPTH(DEPTH)) DUT (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fwd_partial_reset_n(fwd_n), .rev_partial_reset_n(rev_n),
        .porta_xfer_en(a_en), .porta_select_n(a_seln), .porta_dir_sel(a_dir),
        .porta_mail_sel(a_mb), .porta_din(a_din), .porta_dout(a_dout),
        .porta_dout_oe(a_oe), .porta_in_ready(a_rdy), .portb_xfer_en(b_en),
        .portb_select_n(b_seln), .portb_dir_sel(b_dir), .portb_mail_sel(1'b0),
        .portb_din(b_din), .portb_dout(b_dout), .portb_dout_oe(b_oe),
        .portb_in_ready(b_rdy), .fwd_mail_full_n(mail_n));
    bfr_portb_agent u_far (.clk(clk), .resetn(resetn), .cmd(b_cmd),
        .wdat(b_dat), .xfer_en(b_en), .select_n(b_seln), .dir_sel(b_dir),
        .din(b_din));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // one transfer on port a (p=0) or port b (p=1), wr=1 writes
    task automatic xf(input logic p, input logic wr, input logic [35:0] d);
        int g = 0;
        @(posedge clk);
        if (p) begin
            b_cmd <= wr ? 2'd2 : 2'd1;
            b_dat <= d;
        end else begin
            {a_en, a_seln, a_dir, a_din} <= {2'b10, wr, d};
        end
        do begin
            @(posedge clk);
            g++;
        end while (wr && (p ? b_rdy : a_rdy) !== 1'b1 && g < 8);
        ok = (g < 8);
        {b_cmd, a_en, a_seln} <= 4'b0001;
        a_din <= ~d;
        #1 q = p ? b_dout : a_dout;
    endtask
    task automatic rd_chk(input logic p, input logic [35:0] e);
        xf(p, 0, '0);
        chk(q, e);
    endtask
    task automatic prst(input logic rev);
        @(posedge clk);
        if (rev)
            rev_n <= 0;
        else
            fwd_n <= 0;
        repeat (4) @(posedge clk);
        fwd_n <= 1;
        rev_n <= 1;
        #1;
    endtask
    task automatic t_regs();
        apb(0, ADDR_CTRL, '0);
        chk(36'(rd), 36'(CTRL_RESET));
        apb(1, ADDR_STAT, '1);
        apb(0, ADDR_STAT, '0);
        chk(36'(rd), 36'h15);
        apb(0, 8'h08, '0);
        chk(36'({er, rd}), 36'h100000000);
    endtask
    task automatic t_fwd();
        for (int i = 0; i < 3; i++) xf(0, 1, 36'hc0de00 + 36'(i));
        repeat (3) @(posedge clk);
        apb(1, ADDR_CTRL, 32'h5);
        for (int i = 0; i < 3; i++) rd_chk(1, 36'hc0de00 + 36'(i));
        prst(0);
        for (int i = 0; i < 3; i++) rd_chk(1, 36'hc0de00 + 36'(i));
        apb(1, ADDR_CTRL, 32'h2);
        a_mb <= 1;
        xf(0, 1, 36'h1);
        a_mb <= 0;
        chk(36'(mail_n), 36'h0);
        prst(0);
        chk(b_dout, '0);
        chk(36'(mail_n), 36'h1);
        apb(0, ADDR_STAT, '0);
        chk(36'(rd), 36'h15);
        apb(0, ADDR_CTRL, '0);
        chk(36'(rd), 36'h2);
    endtask
    task automatic t_narrow();
        w = 36'h9abcdef12;
        xf(0, 1, w);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 2; i++) rd_chk(1, 36'(w[18*i +: 18]));
        apb(1, ADDR_CTRL, 32'h6);
        w = ~w;
        xf(0, 1, w);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) rd_chk(1, 36'(w[9*i +: 9]));
    endtask
    task automatic t_rev();
        apb(1, ADDR_CTRL, 32'h0);
        for (int i = 0; i < 2; i++) xf(1, 1, 36'h5a5a00010 + 36'(i));
        repeat (3) @(posedge clk);
        for (int i = 0; i < 2; i++) rd_chk(0, 36'h5a5a00010 + 36'(i));
        apb(1, ADDR_CTRL, 32'h1);
        prst(1);
        rd_chk(0, 36'h5a5a00010);
        apb(1, ADDR_CTRL, 32'h0);
        prst(1);
        chk(a_dout, '0);
        apb(0, ADDR_STAT, '0);
        chk(36'(rd[STAT_REV_EMPTY_BIT]), 36'h1);
    endtask
    task automatic t_buf();
        n = 0;
        for (int i = 0; i < 12; i++) begin
            xf(0, 1, 36'h300 + 36'(i));
            if (!ok)
                break;
            n++;
        end
        chk(36'(n), 36'(DEPTH + 2));
        for (int i = 0; i < n; i++) rd_chk(1, 36'h300 + 36'(i));
        apb(0, ADDR_STAT, '0);
        chk(36'(rd[STAT_FWD_EMPTY_BIT]), 36'h1);
    endtask
    initial begin
        resetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fwd_n, rev_n, a_seln} = 3'h7;
        {a_en, a_dir, a_din, b_cmd, b_dat, a_mb} = '0;
        repeat (8) @(posedge clk);
        resetn <= 1;
        t_regs();
        t_fwd();
        t_narrow();
        t_rev();
        t_buf();
        finish_test();
    end
endmodule
`default_nettype wire
